// ---- design/pdp_dma.sv ----
// port dma engine with post-operation directives
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "pdp_params.svh"
module pdp_dma (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic cmd_ready,
  // cell interface counters
  input wire logic rx_cell_done,
  input wire logic tx_cell_done,
  output logic cell_rx_enable_n,
  output logic tx_cell_ready,
  // cell buffer memory
  output pdp_pkg::pdp_haddr_t lbuf_addr,
  output logic [15:0] lbuf_wdata,
  output logic lbuf_we,
  input wire logic [15:0] lbuf_rdata,
  // crc feed
  output logic [15:0] crc_data,
  output logic [1:0] crc_byte_en,
  output logic crc_valid,
  // port a
  output logic port_a_req_n,
  output logic port_a_rd,
  output logic port_a_end_n,
  output logic port_a_irdy_n,
  output logic [1:0] port_a_half_enable,
  output logic [31:0] port_a_addr_data_o,
  output logic port_a_addr_data_oe_n,
  input wire logic [31:0] port_a_addr_data_i,
  input wire logic port_a_asel_n,
  input wire logic port_a_trdy_n,
  // port b
  output logic port_b_req_n,
  output logic port_b_rd,
  output logic port_b_end_n,
  output logic port_b_irdy_n,
  output logic port_b_ale,
  output logic port_b_strobe_n,
  output logic [31:0] port_b_addr_data_o,
  output logic port_b_addr_data_oe_n,
  input wire logic [31:0] port_b_addr_data_i,
  input wire logic port_b_asel_n,
  input wire logic port_b_trdy_n
);
  import pdp_pkg::*;

  pdp_state_t st;
  pdp_state_t next_st;
  logic [67:0] sync1;
  logic [67:0] sync2;
  logic [31:0] cfg;
  logic [8:0] rla [0:3];
  logic [31:0] cmd_addr;
  logic [3:0] rx_full;
  logic [3:0] tx_busy;
  logic [3:0] ph;
  logic c_portb;
  logic c_write;
  logic c_plus;
  logic c_pod;
  logic c_burst;
  logic [1:0] c_rsel;
  logic [31:0] ext;
  logic [8:0] loc;
  logic [7:0] left;
  logic hold_v;
  logic [7:0] hold_b;
  logic crc_defer;
  logic [15:0] wr_half;
  logic [31:0] pad;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [`PDP_FIFO_W-1:0] f_out_data;
  logic [5:0] f_level;
  logic ld;
  logic asel_s;
  logic trdy_s;
  logic [31:0] din;
  logic [15:0] hin;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [1:0] nb;
  logic last;
  logic beat;
  logic nonburst;
  logic end_odd;
  logic [3:0] wait_n;
  pdp_state_t after_addr;
  logic [31:0] next_ext;
  logic [8:0] next_loc;
  logic [7:0] next_left;
  logic next_portb;
  logic next_write;
  logic next_last;
  logic act;
  logic drive;
  logic rx_dec;
  logic tx_inc;

  // bytes moved by one data beat
  function automatic logic [1:0] pdp_nb(input logic [7:0] cnt, input logic odd, input logic wr);
    pdp_nb = (cnt == 8'h01 || (odd && !wr)) ? 2'h1 : 2'h2;
  endfunction

  // halfword lane picked by byte address bit 1
  function automatic logic [15:0] pdp_lane(input logic [31:0] w, input logic lo);
    pdp_lane = lo ? w[15:0] : w[31:16];
  endfunction

  pdp_fifo #(
    .W(`PDP_FIFO_W),
    .DEPTH(`PDP_FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({cmd_addr, reg_wdata[`PDP_CMD_W-1:0]}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data),
    .level(f_level)
  );

  // pin inputs pass two flops
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= `PDP_SYNC_RESET;
      sync2 <= `PDP_SYNC_RESET;
    end
    else
    begin
      sync1 <= {port_a_asel_n, port_a_trdy_n, port_b_asel_n, port_b_trdy_n, port_a_addr_data_i, port_b_addr_data_i};
      sync2 <= sync1;
    end
  end

  assign f_in_valid = reg_wr && reg_addr == `PDP_OFF_CMD;
  assign f_out_ready = (st == st_idle);
  assign ld = (st == st_idle) && f_out_valid;
  assign asel_s = c_portb ? sync2[65] : sync2[67];
  assign trdy_s = c_portb ? sync2[64] : sync2[66];
  assign din = c_portb ? sync2[31:0] : sync2[63:32];
  assign hin = pdp_lane(din, ext[1]);
  assign b0 = ext[0] ? hin[7:0] : hin[15:8];
  assign b1 = hin[7:0];
  assign nb = pdp_nb(left, ext[0], c_write);
  assign last = left <= {6'h00, nb};
  assign nonburst = c_portb && !c_burst;
  assign beat = (st == st_data) && (nonburst || !trdy_s);
  assign end_odd = loc[0] ^ nb[0];
  assign wait_n = cfg[`PDP_CFG_WAIT_LSB+3:`PDP_CFG_WAIT_LSB];
  assign after_addr = (nonburst && wait_n != 4'h0) ? st_wait : st_data;
  assign next_ext = ld ? f_out_data[`PDP_FIFO_W-1:`PDP_CMD_W] : (beat ? ext + {30'h0000_0000, nb} : ext);
  assign next_loc = ld ? rla[f_out_data[`PDP_CMD_RSEL_LSB+1:`PDP_CMD_RSEL_LSB]] :
    (beat ? loc + {7'h00, nb} : loc);
  assign next_left = ld ? {1'b0, f_out_data[`PDP_CMD_CNT_MSB:0]} : (beat ? left - {6'h00, nb} : left);
  assign next_portb = ld ? f_out_data[`PDP_CMD_PORTB_BIT] : c_portb;
  assign next_write = ld ? f_out_data[`PDP_CMD_WRITE_BIT] : c_write;
  assign next_last = next_left <= {6'h00, pdp_nb(next_left, next_ext[0], next_write)};
  assign act = next_st == st_req || next_st == st_addr || next_st == st_fetch || next_st == st_wait
    || next_st == st_data;
  assign drive = next_st == st_addr || (next_write && act && next_st != st_req);
  assign rx_dec = (st == st_post) && c_pod && c_write;
  assign tx_inc = (st == st_post) && c_pod && !c_write;

  // transfer sequencing
  always_comb
  begin
    next_st = st;
    case (st)
      st_idle:
        if (f_out_valid)
          next_st = (f_out_data[`PDP_CMD_CNT_MSB:0] == 7'h00) ? st_post : st_req;
      st_req:
        if (!asel_s)
          next_st = st_addr;
      st_addr:
        if (nonburst || asel_s)
          next_st = c_write ? st_fetch : after_addr;
      st_fetch:
        if (ph == `PDP_FETCH_CYCLES)
          next_st = after_addr;
      st_wait:
        if (ph + 4'h1 >= wait_n)
          next_st = st_data;
      st_data:
        if (beat)
          next_st = last ? st_clean : (nonburst ? st_addr : (c_write ? st_fetch : st_data));
      st_clean:
        next_st = st_post;
      st_post:
        next_st = st_idle;
      default:
        next_st = st_idle;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= st_idle;
    else
      st <= next_st;
  end

  always_ff @(posedge clk)
  begin
    if (rst || next_st != st)
      ph <= 4'h0;
    else
      ph <= ph + 4'h1;
  end

  // command fields and address counters
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      c_portb <= 1'b0;
      c_write <= 1'b0;
      c_plus <= 1'b0;
      c_pod <= 1'b0;
      c_burst <= 1'b0;
      c_rsel <= 2'h0;
      ext <= 32'h0000_0000;
      loc <= 9'h000;
      left <= 8'h00;
    end
    else
    begin
      ext <= next_ext;
      loc <= next_loc;
      left <= next_left;
      c_portb <= next_portb;
      c_write <= next_write;
      if (ld)
      begin
        c_plus <= f_out_data[`PDP_CMD_PLUS_BIT];
        c_pod <= f_out_data[`PDP_CMD_POD_BIT];
        c_burst <= f_out_data[`PDP_CMD_BURST_BIT];
        c_rsel <= f_out_data[`PDP_CMD_RSEL_LSB+1:`PDP_CMD_RSEL_LSB];
      end
    end
  end

  // byte realignment into the cell buffer and crc feed
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_v <= 1'b0;
      hold_b <= 8'h00;
      crc_defer <= 1'b0;
      lbuf_we <= 1'b0;
      lbuf_wdata <= 16'h0000;
      crc_valid <= 1'b0;
      crc_data <= 16'h0000;
      crc_byte_en <= 2'h0;
    end
    else
    begin
      lbuf_we <= 1'b0;
      crc_valid <= 1'b0;
      if (ld && crc_defer)
      begin
        crc_valid <= 1'b1;
        crc_data <= {hold_b, 8'h00};
        crc_byte_en <= 2'b10;
        crc_defer <= 1'b0;
      end
      else if (beat && c_write)
      begin
        crc_valid <= 1'b1;
        crc_data <= wr_half;
        crc_byte_en <= 2'b11;
      end
      else if (beat)
      begin
        lbuf_we <= loc[0] || nb == 2'h2;
        lbuf_wdata <= loc[0] ? {hold_b, b0} : {b0, b1};
        if (!loc[0] && nb == 2'h1)
        begin
          hold_b <= b0;
          hold_v <= 1'b1;
        end
        else if (loc[0] && nb == 2'h2)
        begin
          hold_b <= b1;
          hold_v <= 1'b1;
        end
        else
          hold_v <= 1'b0;
        crc_data <= {b0, b1};
        if (last && end_odd)
        begin
          crc_valid <= nb == 2'h2;
          crc_byte_en <= (nb == 2'h2) ? 2'b10 : 2'b00;
          crc_defer <= 1'b1;
        end
        else
        begin
          crc_valid <= 1'b1;
          crc_byte_en <= (nb == 2'h2) ? 2'b11 : 2'b10;
        end
      end
    end
  end

  // cell buffer address and outgoing data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lbuf_addr <= 8'h00;
      wr_half <= 16'h0000;
      pad <= 32'h0000_0000;
    end
    else
    begin
      lbuf_addr <= loc[8:1];
      if (next_st == st_addr)
        pad <= next_ext;
      else if (st == st_fetch && ph == `PDP_FETCH_CYCLES)
      begin
        pad <= {lbuf_rdata, lbuf_rdata};
        wr_half <= lbuf_rdata;
      end
    end
  end

  assign port_a_addr_data_o = pad;
  assign port_b_addr_data_o = pad;

  // bus pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port_a_req_n <= 1'b1;
      port_b_req_n <= 1'b1;
      port_a_rd <= 1'b1;
      port_b_rd <= 1'b1;
      port_a_end_n <= 1'b1;
      port_b_end_n <= 1'b1;
      port_a_irdy_n <= 1'b1;
      port_b_irdy_n <= 1'b1;
      port_a_half_enable <= 2'h0;
      port_a_addr_data_oe_n <= 1'b1;
      port_b_addr_data_oe_n <= 1'b1;
      port_b_ale <= 1'b0;
      port_b_strobe_n <= 1'b1;
    end
    else
    begin
      port_a_req_n <= !(act && !next_portb);
      port_b_req_n <= !(act && next_portb);
      port_a_rd <= !next_write;
      port_b_rd <= !next_write;
      port_a_end_n <= !(next_st == st_data && next_last && !next_portb);
      port_b_end_n <= !(next_st == st_data && next_last && next_portb);
      port_a_irdy_n <= !(next_st == st_data && !next_portb);
      port_b_irdy_n <= !(next_st == st_data && next_portb);
      port_a_half_enable <= (next_st == st_data && !next_portb) ? (next_ext[1] ? 2'b10 : 2'b01) : 2'b00;
      port_a_addr_data_oe_n <= !(drive && !next_portb);
      port_b_addr_data_oe_n <= !(drive && next_portb);
      port_b_ale <= next_st == st_addr && nonburst;
      port_b_strobe_n <= !(nonburst && (next_st == st_wait || next_st == st_data));
    end
  end

  // cell interface counters
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_full <= 4'h0;
      tx_busy <= 4'h0;
    end
    else
    begin
      case ({rx_cell_done, rx_dec})
        2'b10: if (rx_full != 4'hf) rx_full <= rx_full + 4'h1;
        2'b01: if (rx_full != 4'h0) rx_full <= rx_full - 4'h1;
        default: rx_full <= rx_full;
      endcase
      case ({tx_inc, tx_cell_done})
        2'b10: if (tx_busy != 4'hf) tx_busy <= tx_busy + 4'h1;
        2'b01: if (tx_busy != 4'h0) tx_busy <= tx_busy - 4'h1;
        default: tx_busy <= tx_busy;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cell_rx_enable_n <= 1'b1;
      tx_cell_ready <= 1'b0;
      cmd_ready <= 1'b0;
    end
    else
    begin
      cell_rx_enable_n <= rx_full >= cfg[`PDP_CFG_RXLIM_LSB+3:`PDP_CFG_RXLIM_LSB];
      tx_cell_ready <= tx_busy != 4'h0;
      cmd_ready <= f_in_ready;
    end
  end

  // software registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg <= `PDP_CONFIG_RESET;
      cmd_addr <= `PDP_CMD_ADDR_RESET;
      for (int i = 0; i < 4; i++)
        rla[i] <= `PDP_RLA_RESET;
    end
    else
    begin
      if (reg_wr && reg_addr == `PDP_OFF_CONFIG)
        cfg <= reg_wdata;
      if (reg_wr && reg_addr == `PDP_OFF_CMD_ADDR)
        cmd_addr <= reg_wdata;
      for (int i = 0; i < 4; i++)
      begin
        if (reg_wr && reg_addr == `PDP_OFF_RLA0 + 4'(i))
          rla[i] <= reg_wdata[8:0];
        else if (st == st_post && c_plus && cfg[`PDP_CFG_PLUS_BIT] && c_rsel == 2'(i))
          rla[i] <= rla[i] + `PDP_RLA_STEP;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || !reg_rd)
      reg_rdata <= 32'h0000_0000;
    else
    begin
      case (reg_addr)
        `PDP_OFF_CONFIG: reg_rdata <= cfg;
        `PDP_OFF_RLA0: reg_rdata <= {23'h00_0000, rla[0]};
        `PDP_OFF_RLA1: reg_rdata <= {23'h00_0000, rla[1]};
        `PDP_OFF_RLA2: reg_rdata <= {23'h00_0000, rla[2]};
        `PDP_OFF_RLA3: reg_rdata <= {23'h00_0000, rla[3]};
        `PDP_OFF_CMD_ADDR: reg_rdata <= cmd_addr;
        `PDP_OFF_STATUS: reg_rdata <= {18'h0_0000, f_level, 5'h00, hold_v, f_in_ready, st != st_idle};
        `PDP_OFF_COUNTS: reg_rdata <= {24'h00_0000, tx_busy, rx_full};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // pdp_dma

// ---- design/pdp_fifo.sv ----
// command fifo with registered read data
`timescale 1ns/1ps
module pdp_fifo #(
  parameter int W = 46,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic push;
  logic pop;

  assign in_ready = (level != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  // refill output stage when empty or being taken
  assign pop = (level != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp <= '0;
      rp <= '0;
      level <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'b1;
      if (pop)
        rp <= rp + 1'b1;
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rp];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end
endmodule // pdp_fifo

// ---- design/pdp_params.svh ----
// constants for the port dma post-operation block
`ifndef PDP_PARAMS_SVH
`define PDP_PARAMS_SVH
`define PDP_OFF_CONFIG 4'h0
`define PDP_OFF_RLA0 4'h1
`define PDP_OFF_RLA1 4'h2
`define PDP_OFF_RLA2 4'h3
`define PDP_OFF_RLA3 4'h4
`define PDP_OFF_CMD_ADDR 4'h5
`define PDP_OFF_CMD 4'h6
`define PDP_OFF_STATUS 4'h7
`define PDP_OFF_COUNTS 4'h8
`define PDP_CONFIG_RESET 32'h0000_0000
`define PDP_RLA_RESET 9'h000
`define PDP_CMD_ADDR_RESET 32'h0000_0000
`define PDP_SYNC_RESET 68'hf_0000_0000_0000_0000
`define PDP_CFG_PLUS_BIT 5
`define PDP_CFG_WAIT_LSB 8
`define PDP_CFG_RXLIM_LSB 12
`define PDP_RLA_STEP 9'h040
`define PDP_CMD_CNT_MSB 6
`define PDP_CMD_PORTB_BIT 7
`define PDP_CMD_WRITE_BIT 8
`define PDP_CMD_PLUS_BIT 9
`define PDP_CMD_POD_BIT 10
`define PDP_CMD_BURST_BIT 11
`define PDP_CMD_RSEL_LSB 12
`define PDP_CMD_W 14
`define PDP_FIFO_W 46
`define PDP_FIFO_DEPTH 32
`define PDP_FETCH_CYCLES 4'h2
`endif

// ---- design/pdp_pkg.sv ----
// types for the port dma post-operation block
package pdp_pkg;
  typedef enum logic [2:0] {
    st_idle, st_req, st_addr, st_fetch, st_wait, st_data, st_clean, st_post
  } pdp_state_t;
  typedef logic [7:0] pdp_haddr_t;
endpackage

// ---- test/pdp_dma_properties.sv ----
// pin-level assertions for the port dma block
`timescale 1ns/1ps
module pdp_dma_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // port a
  input wire logic port_a_req_n,
  input wire logic port_a_rd,
  input wire logic port_a_end_n,
  input wire logic port_a_irdy_n,
  input wire logic [1:0] port_a_half_enable,
  input wire logic port_a_addr_data_oe_n,
  // port b
  input wire logic port_b_req_n,
  input wire logic port_b_rd,
  input wire logic port_b_irdy_n,
  input wire logic port_b_ale,
  input wire logic port_b_strobe_n,
  input wire logic port_b_addr_data_oe_n,
  // crc feed
  input wire logic [1:0] crc_byte_en,
  input wire logic crc_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_half_sel;
    port_a_half_enable != 2'b00 |-> !port_a_irdy_n && port_a_half_enable != 2'b11;
  endproperty
  a_half_sel: assert property (p_half_sel) else $error("half enable outside a data cycle");
  property p_a_wr_drive;
    !port_a_irdy_n && !port_a_rd |-> !port_a_addr_data_oe_n;
  endproperty
  a_a_wr_drive: assert property (p_a_wr_drive) else $error("port a write data not driven");
  property p_a_rd_float;
    !port_a_irdy_n && port_a_rd |-> port_a_addr_data_oe_n;
  endproperty
  a_a_rd_float: assert property (p_a_rd_float) else $error("port a drives during read data");
  property p_b_rd_float;
    !port_b_irdy_n && port_b_rd |-> port_b_addr_data_oe_n;
  endproperty
  a_b_rd_float: assert property (p_b_rd_float) else $error("port b drives during read data");
  property p_a_end;
    !port_a_end_n |-> !port_a_irdy_n && !port_a_req_n;
  endproperty
  a_a_end: assert property (p_a_end) else $error("port a last cycle outside data");
  property p_a_release;
    $fell(port_a_end_n) |-> ##[1:16] port_a_req_n;
  endproperty
  a_a_release: assert property (p_a_release) else $error("port a request kept after last cycle");
  property p_crc_bytes;
    crc_valid |-> crc_byte_en != 2'b00;
  endproperty
  a_crc_bytes: assert property (p_crc_bytes) else $error("crc strobe with no byte");
  property p_ale_once;
    port_b_ale |=> !port_b_ale ##[0:3] !port_b_strobe_n;
  endproperty
  a_ale_once: assert property (p_ale_once) else $error("non-burst address cycle not single");
  property p_ale_addr;
    port_b_ale |-> !port_b_req_n && !port_b_addr_data_oe_n;
  endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("non-burst address not driven");
endmodule // pdp_dma_properties

bind pdp_dma pdp_dma_properties u_props (.clk(clk), .rst(rst), .port_a_req_n(port_a_req_n),
  .port_a_rd(port_a_rd), .port_a_end_n(port_a_end_n), .port_a_irdy_n(port_a_irdy_n),
  .port_a_half_enable(port_a_half_enable), .port_a_addr_data_oe_n(port_a_addr_data_oe_n),
  .port_b_req_n(port_b_req_n), .port_b_rd(port_b_rd), .port_b_irdy_n(port_b_irdy_n),
  .port_b_ale(port_b_ale), .port_b_strobe_n(port_b_strobe_n),
  .port_b_addr_data_oe_n(port_b_addr_data_oe_n), .crc_byte_en(crc_byte_en), .crc_valid(crc_valid));

// ---- test/pdp_host_model.sv ----
// arbiter and host memory beside one dma port
`timescale 1ns/1ps
module pdp_host_model #(
  parameter int SLOW = 0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // port pins
  input wire logic req_n,
  input wire logic rd,
  input wire logic irdy_n,
  input wire logic [31:0] ad_o,
  input wire logic ad_oe_n,
  output logic asel_n,
  output logic trdy_n,
  output logic [31:0] ad_i
);
  logic granted;
  logic [3:0] gap;
  logic [7:0] beats;
  logic [15:0] cyc;
  // wire level: device, read data while granted, else changing noise
  assign ad_i = !ad_oe_n ? ad_o : (granted && rd) ? {24'h00a5_c3, beats} : {cyc, ~cyc};
  always @(posedge clk)
  begin
    if (rst)
    begin
      asel_n <= 1'b1;
      trdy_n <= 1'b1;
      granted <= 1'b0;
      gap <= 4'h0;
      beats <= 8'h00;
      cyc <= 16'h0000;
    end
    else
    begin
      cyc <= cyc + 16'h0001;
      trdy_n <= 1'b1;
      if (gap != 4'h0)
        gap <= gap - 4'h1;
      if (req_n)
      begin
        asel_n <= 1'b1;
        granted <= 1'b0;
      end
      else if (!granted)
      begin
        // select address cycle until it shows on the wire
        asel_n <= !ad_oe_n;
        granted <= !ad_oe_n;
      end
      else if (!irdy_n && gap == 4'h0)
      begin
        // one-cycle beat, spaced so the synchroniser sees one
        trdy_n <= 1'b0;
        beats <= beats + 8'h01;
        gap <= 4'h5 + (SLOW != 0 ? 4'($urandom_range(0, 6)) : 4'h0);
      end
    end
  end
endmodule // pdp_host_model

// ---- test/test_port_dma_post_ops.sv ----
// self-checking bench for the port dma block
`timescale 1ns/1ps
`include "pdp_params.svh"
module test_port_dma_post_ops;
  import pdp_pkg::*;
  logic clk, rst, reg_wr, reg_rd, cmd_ready, rx_cell_done, tx_cell_done, cell_rx_enable_n, tx_cell_ready;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, port_a_addr_data_o, port_a_addr_data_i, port_b_addr_data_o, port_b_addr_data_i;
  pdp_haddr_t lbuf_addr;
  logic [15:0] lbuf_wdata, lbuf_rdata, crc_data;
  logic [1:0] crc_byte_en, port_a_half_enable;
  logic lbuf_we, crc_valid, port_a_req_n, port_a_rd, port_a_end_n, port_a_irdy_n, port_a_addr_data_oe_n;
  logic port_a_asel_n, port_a_trdy_n, port_b_req_n, port_b_rd, port_b_end_n, port_b_irdy_n, port_b_ale;
  logic port_b_strobe_n, port_b_addr_data_oe_n, port_b_asel_n, port_b_trdy_n;
  int err_total, samples_checked;
  logic [8:0] rla_m[4];
  logic [3:0] rx_m, tx_m;
  logic cfg_plus;
  pdp_dma dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_ready, .rx_cell_done,
    .tx_cell_done, .cell_rx_enable_n, .tx_cell_ready, .lbuf_addr, .lbuf_wdata, .lbuf_we, .lbuf_rdata, .crc_data,
    .crc_byte_en, .crc_valid, .port_a_req_n, .port_a_rd, .port_a_end_n, .port_a_irdy_n, .port_a_half_enable,
    .port_a_addr_data_o, .port_a_addr_data_oe_n, .port_a_addr_data_i, .port_a_asel_n, .port_a_trdy_n,
    .port_b_req_n, .port_b_rd, .port_b_end_n, .port_b_irdy_n, .port_b_ale, .port_b_strobe_n, .port_b_addr_data_o,
    .port_b_addr_data_oe_n, .port_b_addr_data_i, .port_b_asel_n, .port_b_trdy_n);
  pdp_host_model #(.SLOW(0)) u_host_a (.clk, .rst, .req_n(port_a_req_n), .rd(port_a_rd), .irdy_n(port_a_irdy_n),
    .ad_o(port_a_addr_data_o), .ad_oe_n(port_a_addr_data_oe_n), .asel_n(port_a_asel_n), .trdy_n(port_a_trdy_n),
    .ad_i(port_a_addr_data_i));
  pdp_host_model #(.SLOW(1)) u_host_b (.clk, .rst, .req_n(port_b_req_n), .rd(port_b_rd), .irdy_n(port_b_irdy_n),
    .ad_o(port_b_addr_data_o), .ad_oe_n(port_b_addr_data_oe_n), .asel_n(port_b_asel_n), .trdy_n(port_b_trdy_n),
    .ad_i(port_b_addr_data_i));
  // cell buffer with registered read, contents in place before any transfer
  always @(posedge clk)
    lbuf_rdata <= {lbuf_addr, ~lbuf_addr};
  // bytes handed to the crc feed so far
  logic [31:0] crc_bytes;
  always @(posedge clk)
    if (rst)
      crc_bytes <= 32'h0000_0000;
    else if (crc_valid)
      crc_bytes <= crc_bytes + {31'h0, crc_byte_en[1]} + {31'h0, crc_byte_en[0]};
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [3:0] bump(input logic [3:0] c, input logic up);
    return up ? ((c == 4'hf) ? c : c + 4'h1) : ((c == 4'h0) ? c : c - 4'h1);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  task automatic pulse(input logic up);
    rx_cell_done <= up;
    tx_cell_done <= !up;
    @(posedge clk);
    rx_cell_done <= 1'b0;
    tx_cell_done <= 1'b0;
    @(posedge clk);
    if (up)
      rx_m = bump(rx_m, 1'b1);
    else
      tx_m = bump(tx_m, 1'b0);
  endtask
  // wait for the queue to drain, then compare counters and rla
  task automatic settle(input logic [13:0] c);
    logic [31:0] d;
    int n;
    d = 32'h0000_0001;
    n = 0;
    repeat (3) @(posedge clk);
    while (d[0] !== 1'b0 || d[13:8] !== 6'h00)
    begin
      rd(`PDP_OFF_STATUS, d);
      n++;
      if (n > 2000)
      begin
        err_total++;
        $display("BAD t=%0t engine never idle", $time);
        wrap_up();
      end
    end
    repeat (3) @(posedge clk);
    if (c[`PDP_CMD_PLUS_BIT] && cfg_plus)
      rla_m[c[13:12]] = rla_m[c[13:12]] + `PDP_RLA_STEP;
    if (c[`PDP_CMD_POD_BIT])
      if (c[`PDP_CMD_WRITE_BIT])
        rx_m = bump(rx_m, 1'b0);
      else
        tx_m = bump(tx_m, 1'b1);
    chk_reg(`PDP_OFF_RLA0 + {2'b00, c[13:12]}, {23'h0, rla_m[c[13:12]]});
    chk_reg(`PDP_OFF_COUNTS, {24'h0, tx_m, rx_m});
    @(negedge clk);
    check({31'h0, cell_rx_enable_n}, {31'h0, rx_m >= 4'h3});
    check({31'h0, tx_cell_ready}, {31'h0, tx_m != 4'h0});
    @(posedge clk);
  endtask
  // every byte of an even cell piece reaches the crc exactly once
  task automatic run(input logic [13:0] c, input logic [31:0] ext);
    logic [31:0] base;
    base = crc_bytes;
    wr(`PDP_OFF_CMD_ADDR, ext);
    wr(`PDP_OFF_CMD, {18'h0, c});
    settle(c);
    check(crc_bytes - base, {25'h0, c[6:0]});
  endtask
  initial
  begin
    logic [31:0] d;
    logic [13:0] c;
    {rst, reg_wr, reg_rd, rx_cell_done, tx_cell_done} = 5'b10000;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    err_total = 0;
    samples_checked = 0;
    rx_m = 4'h0;
    tx_m = 4'h0;
    cfg_plus = 1'b0;
    rla_m = '{default: 9'h000};
    d = $urandom(32'h798189ad);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++)
      if (i < 5 || i > 7)
        chk_reg(4'(i), 32'h0000_0000);
    // plus while stepping is off: deliberate misuse, rla must hold
    wr(`PDP_OFF_CONFIG, 32'h0000_3000);
    wr(`PDP_OFF_RLA0, 32'h0000_01c0);
    rla_m[0] = 9'h1c0;
    run(14'h0204, 32'h0000_0100);
    wr(`PDP_OFF_CONFIG, 32'h0000_3220);
    cfg_plus = 1'b1;
    run(14'h0606, 32'h0000_1001);
    repeat (3) pulse(1'b1);
    wr(`PDP_OFF_RLA1, 32'h0000_0040);
    rla_m[1] = 9'h040;
    run(14'h1784, 32'h0000_2000);
    pulse(1'b0);
    run(14'h2c80, 32'h0000_3000);
    run(14'h2884, 32'h0000_3002);
    run(14'h3508, 32'h0000_4002);
    // random traffic; cell starts and ends kept even
    for (int i = 0; i < 16; i++)
    begin
      c = {2'($urandom), 4'($urandom), 1'b0, 7'(2 * $urandom_range(0, 6))};
      c[`PDP_CMD_PLUS_BIT] = $urandom_range(0, 1);
      wr(`PDP_OFF_RLA0 + {2'b00, c[13:12]}, {23'h0, 8'($urandom), 1'b0});
      rla_m[c[13:12]] = {8'(reg_wdata[8:1]), 1'b0};
      if ($urandom_range(0, 1) == 1)
        pulse($urandom_range(0, 1) == 1);
      run(c, $urandom);
    end
    // flood the queue back to back until it refuses
    wr(`PDP_OFF_CMD_ADDR, 32'h0000_0000);
    reg_addr <= `PDP_OFF_CMD;
    reg_wdata <= 32'h0000_008c;
    reg_wr <= 1'b1;
    repeat (40) @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({31'h0, cmd_ready}, 32'h0000_0000);
    settle(14'h008c);
    wrap_up();
  end
endmodule // test_port_dma_post_ops
